// >>> hw/epvs_pkg.sv
package epvs_pkg;
  // Select and function command codes
  localparam logic [7:0] GLOBAL_SELECT_CMD = 8'hcc;
  localparam logic [7:0] UNIQUE_SELECT_CMD = 8'h55;
  localparam logic [7:0] SHORT_ADDRESS_SELECT_CMD = 8'h69;
  localparam logic [7:0] STAGE_WRITE_CMD = 8'h0f;
  localparam logic [7:0] STAGE_READ_CMD = 8'haa;
  localparam logic [7:0] STAGE_COPY_CMD = 8'h55;
  localparam logic [7:0] COPY_QUALIFIER = 8'ha5;
  localparam logic [7:0] READ_EEPROM_CMD = 8'hf0;
  // Sizes and reset values
  localparam logic [3:0] PAGE_BYTES = 4'h8;
  localparam logic [3:0] ID_BYTES = 4'h8;
  localparam int EE_BYTES = 256;
  localparam logic [15:0] EE_END = 16'h0100;
  localparam logic [7:0] EE_ERASED = 8'hff;
  localparam logic [7:0] PAST_END_BYTE = 8'hff;
  localparam logic [7:0] CRC_INIT = 8'h00;
  localparam logic [7:0] CRC_POLY_REFL = 8'h8c;
  // Timing: clock period and idle times in ns
  localparam int CLK_PERIOD_NS = 100;
  localparam int PROGRAM_IDLE_TIME_NS = 200000;
  localparam int PREFETCH_IDLE_TIME_NS = 5000;
  localparam logic [15:0] PROGRAM_IDLE_CYCLES =
    16'((PROGRAM_IDLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] PREFETCH_IDLE_CYCLES =
    16'((PREFETCH_IDLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] PRESENCE_TIMEOUT_CYCLES = 16'h0010;

  // Device states
  typedef enum logic [3:0] {
    D_IDLE = 4'b0000, D_ROM = 4'b0001, D_MATCH = 4'b0010, D_SHORT = 4'b0011,
    D_FUNC = 4'b0100, D_WADDR = 4'b0101, D_WDATA = 4'b0110, D_WCRC = 4'b0111,
    D_RADDR = 4'b1000, D_RDATA = 4'b1001, D_QUAL = 4'b1010, D_PROG = 4'b1011,
    D_EADDR = 4'b1100, D_EDATA = 4'b1101, D_DONE = 4'b1110
  } epvs_dev_state_type;

  // Host states
  typedef enum logic [2:0] {
    H_IDLE = 3'b000, H_RST = 3'b001, H_PRES = 3'b010, H_TX = 3'b011,
    H_RX = 3'b100, H_WAIT = 3'b101, H_END = 3'b110
  } epvs_host_state_type;

  // Host phases of one job
  typedef enum logic [1:0] {
    P_STAGE = 2'b00, P_VERIFY = 2'b01, P_COPY = 2'b10, P_READ = 2'b11
  } epvs_phase_type;

  // CRC-8, reflected, one byte least significant bit first
  function automatic logic [7:0] epvs_crc8(input logic [7:0] crc_in, input logic [7:0] data);
    logic [7:0] c;
    logic fb;
    c = crc_in;
    for (int i = 0; i < 8; i++)
    begin
      fb = c[0] ^ data[i];
      c = c >> 1;
      if (fb)
      begin
        c = c ^ CRC_POLY_REFL;
      end
    end
    return c;
  endfunction : epvs_crc8
endpackage : epvs_pkg

// >>> hw/epvs_link_if.sv
`timescale 1ns/100ps
// Byte-level single-wire link between host and device
interface epvs_link_if;
  logic bus_reset;
  logic presence;
  logic h_valid;
  logic [7:0] h_data;
  logic rd_req;
  logic d_valid;
  logic [7:0] d_data;
  modport dev (input bus_reset, h_valid, h_data, rd_req, output presence, d_valid, d_data);
  modport host (output bus_reset, h_valid, h_data, rd_req, input presence, d_valid, d_data);
endinterface : epvs_link_if

// >>> hw/epvs_device.sv
`timescale 1ns/100ps
module epvs_device #(
  parameter logic [63:0] DEV_ID = 64'h0123_4567_89ab_cdef, // arbitrary value
  parameter logic [7:0] SHORT_ADDR = 8'h01
) (
  input wire logic CLK_IN,
  input wire logic NRST_IN,
  epvs_link_if.dev LINK,
  output logic PROG_BUSY_OUT,
  output logic SELECTED_OUT
);
  import epvs_pkg::*;

  typedef struct packed {
    epvs_dev_state_type state;
    logic [3:0] cnt;
    logic [7:0] crc;
    logic match_ok;
    logic past_end;
    logic [15:0] addr;
    logic [15:0] stg_addr;
    logic [7:0][7:0] stg_data;
    logic [EE_BYTES-1:0][7:0] mem;
    logic [15:0] prog_cnt;
    logic pres;
    logic dv;
    logic [7:0] dd;
    logic busy;
    logic sel;
  } epvs_dev_reg_type;

  epvs_dev_reg_type s_reg;
  epvs_dev_reg_type s_next;
  logic [7:0] hb;

  assign hb = LINK.h_data;

  // Next-state logic of the whole device
  always_comb
  begin
    s_next = s_reg;
    s_next.pres = 1'b0;
    s_next.dv = 1'b0;
    if (LINK.bus_reset && s_reg.state != D_PROG)
    begin
      // Presence answer, then wait for a select command
      s_next.pres = 1'b1;
      s_next.state = D_ROM;
      s_next.sel = 1'b0;
      s_next.cnt = 4'h0;
    end
    else
    begin
      case (s_reg.state)
        D_ROM:
          if (LINK.h_valid)
          begin
            s_next.cnt = 4'h0;
            s_next.match_ok = 1'b1;
            if (hb == GLOBAL_SELECT_CMD)
            begin
              s_next.state = D_FUNC;
              s_next.sel = 1'b1;
            end
            else if (hb == UNIQUE_SELECT_CMD)
            begin
              s_next.state = D_MATCH;
            end
            else if (hb == SHORT_ADDRESS_SELECT_CMD)
            begin
              s_next.state = D_SHORT;
            end
            else
            begin
              s_next.state = D_DONE;
            end
          end
        D_MATCH:
          if (LINK.h_valid)
          begin
            s_next.match_ok = s_reg.match_ok & (hb == DEV_ID[8*s_reg.cnt[2:0] +: 8]);
            s_next.cnt = s_reg.cnt + 4'h1;
            if (s_reg.cnt == ID_BYTES - 4'h1)
            begin
              s_next.sel = s_next.match_ok;
              s_next.state = s_next.match_ok ? D_FUNC : D_DONE;
            end
          end
        D_SHORT:
          if (LINK.h_valid)
          begin
            s_next.sel = (hb == SHORT_ADDR);
            s_next.state = (hb == SHORT_ADDR) ? D_FUNC : D_DONE;
          end
        D_FUNC:
          if (LINK.h_valid)
          begin
            s_next.crc = CRC_INIT;
            s_next.cnt = 4'h0;
            if (hb == STAGE_WRITE_CMD)
            begin
              s_next.state = D_WADDR;
            end
            else if (hb == STAGE_READ_CMD)
            begin
              s_next.state = D_RADDR;
            end
            else if (hb == STAGE_COPY_CMD)
            begin
              s_next.state = D_QUAL;
            end
            else if (hb == READ_EEPROM_CMD)
            begin
              s_next.state = D_EADDR;
            end
            else
            begin
              s_next.state = D_DONE;
            end
          end
        D_WADDR:
          if (LINK.h_valid)
          begin
            s_next.stg_addr = {s_reg.stg_addr[7:0], hb};
            s_next.crc = epvs_crc8(s_reg.crc, hb);
            s_next.cnt = s_reg.cnt + 4'h1;
            if (s_reg.cnt == 4'h1)
            begin
              s_next.cnt = 4'h0;
              s_next.state = D_WDATA;
            end
          end
        D_WDATA:
          if (LINK.h_valid)
          begin
            s_next.stg_data[s_reg.cnt[2:0]] = hb;
            // crc runs over address and data
            s_next.crc = epvs_crc8(s_reg.crc, hb);
            s_next.cnt = s_reg.cnt + 4'h1;
            if (s_reg.cnt == PAGE_BYTES - 4'h1)
            begin
              s_next.state = D_WCRC;
            end
          end
        D_WCRC:
          if (LINK.rd_req)
          begin
            s_next.dv = 1'b1;
            s_next.dd = s_reg.crc;
            s_next.state = D_DONE;
          end
        D_RADDR:
          if (LINK.h_valid)
          begin
            s_next.cnt = s_reg.cnt + 4'h1;
            if (s_reg.cnt == 4'h1)
            begin
              s_next.cnt = 4'h0;
              s_next.state = D_RDATA;
            end
          end
        D_RDATA:
          if (LINK.rd_req)
          begin
            s_next.dv = 1'b1;
            if (s_reg.cnt == PAGE_BYTES)
            begin
              s_next.dd = s_reg.crc;
              s_next.state = D_DONE;
            end
            else
            begin
              s_next.dd = s_reg.stg_data[s_reg.cnt[2:0]];
              s_next.crc = epvs_crc8(s_reg.crc, s_reg.stg_data[s_reg.cnt[2:0]]);
              s_next.cnt = s_reg.cnt + 4'h1;
            end
          end
        D_QUAL:
          if (LINK.h_valid)
          begin
            if (hb == COPY_QUALIFIER)
            begin
              if (s_reg.stg_addr < EE_END)
              begin
                for (int i = 0; i < 8; i++)
                begin
                  s_next.mem[{s_reg.stg_addr[7:3], 3'(i)}] = s_reg.stg_data[i];
                end
              end
              s_next.prog_cnt = PROGRAM_IDLE_CYCLES - 16'h1;
              s_next.busy = 1'b1;
              s_next.state = D_PROG;
            end
            else
            begin
              s_next.state = D_DONE;
            end
          end
        D_PROG:
          if (s_reg.prog_cnt == 16'h0)
          begin
            s_next.busy = 1'b0;
            s_next.state = D_IDLE;
          end
          else
          begin
            s_next.prog_cnt = s_reg.prog_cnt - 16'h1;
          end
        D_EADDR:
          if (LINK.h_valid)
          begin
            s_next.addr = {s_reg.addr[7:0], hb};
            s_next.cnt = s_reg.cnt + 4'h1;
            if (s_reg.cnt == 4'h1)
            begin
              s_next.cnt = 4'h0;
              s_next.crc = CRC_INIT;
              s_next.past_end = ({s_reg.addr[7:0], hb} >= EE_END);
              s_next.state = D_EDATA;
            end
          end
        D_EDATA:
          if (LINK.rd_req)
          begin
            s_next.dv = 1'b1;
            if (s_reg.past_end)
            begin
              s_next.dd = PAST_END_BYTE;
            end
            else if (s_reg.cnt == PAGE_BYTES)
            begin
              s_next.dd = s_reg.crc;
              s_next.crc = CRC_INIT;
              s_next.cnt = 4'h0;
              s_next.past_end = (s_reg.addr >= EE_END);
            end
            else if (s_reg.addr >= EE_END)
            begin
              s_next.dd = PAST_END_BYTE;
              s_next.past_end = 1'b1;
            end
            else
            begin
              s_next.dd = s_reg.mem[s_reg.addr[7:0]];
              s_next.crc = epvs_crc8(s_reg.crc, s_reg.mem[s_reg.addr[7:0]]);
              s_next.cnt = s_reg.cnt + 4'h1;
              s_next.addr = s_reg.addr + 16'h1;
            end
          end
        default:
          s_next.state = s_reg.state;
      endcase
    end
    if (!NRST_IN)
    begin
      s_next = '0;
      s_next.mem = {EE_BYTES{EE_ERASED}};
    end
  end

  // State register
  always_ff @(posedge CLK_IN)
  begin
    s_reg <= s_next;
  end

  // Outputs straight from the state register
  assign LINK.presence = s_reg.pres;
  assign LINK.d_valid = s_reg.dv;
  assign LINK.d_data = s_reg.dd;
  assign PROG_BUSY_OUT = s_reg.busy;
  assign SELECTED_OUT = s_reg.sel;
endmodule : epvs_device

// >>> hw/epvs_host.sv
`timescale 1ns/100ps
// Functional notes
// - Bus reset and presence before selecting
// - Global select command when device alone
// - Several devices: unique or short select (this host sends unique select only)
// - Stage write: command, address, eight bytes
// - Device returns crc over address, data
// - Stage read returns eight bytes, crc
// - Verify staged content before any commit
// - Copy command plus qualifier programs page
// - Bus stays idle during programming time
// - Whole sequence repeated per page
// - Read command, address, then prefetch idle
// - Pages of eight bytes, each crc
// - Past the end, reads are ones
// - Unique select sends eight address bytes
module epvs_host (
  input wire logic CLK_IN,
  input wire logic NRST_IN,
  epvs_link_if.host LINK,
  input wire logic START_IN,
  input wire logic OP_IN,
  input wire logic MULTI_IN,
  input wire logic [63:0] DEV_ID_IN,
  input wire logic [15:0] ADDR_IN,
  input wire logic [63:0] WDATA_IN,
  output logic BUSY_OUT,
  output logic DONE_OUT,
  output logic ERROR_OUT,
  output logic CRC_OK_OUT,
  output logic [63:0] RDATA_OUT
);
  import epvs_pkg::*;

  typedef struct packed {
    epvs_host_state_type state;
    epvs_phase_type ph;
    logic multi;
    logic [4:0] idx;
    logic [3:0] rcnt;
    logic [7:0] crc;
    logic [15:0] wcnt;
    logic pend;
    logic [7:0][7:0] id;
    logic [15:0] addr;
    logic [7:0][7:0] wd;
    logic [7:0][7:0] rd;
    logic rst;
    logic hv;
    logic [7:0] hd;
    logic rq;
    logic busy;
    logic done;
    logic err;
    logic crc_ok;
  } epvs_host_reg_type;

  epvs_host_reg_type s_reg;
  epvs_host_reg_type s_next;
  logic [4:0] sel_len;
  logic [4:0] tx_len;
  logic [4:0] k;
  logic [7:0] tx_byte;

  // Select length and number of bytes sent per phase
  always_comb
  begin
    sel_len = s_reg.multi ? (5'(ID_BYTES) + 5'h1) : 5'h1;
    case (s_reg.ph)
      P_STAGE: tx_len = sel_len + 5'h3 + 5'(PAGE_BYTES);
      P_VERIFY: tx_len = sel_len + 5'h3;
      P_COPY: tx_len = sel_len + 5'h2;
      default: tx_len = sel_len + 5'h3;
    endcase
    k = s_reg.idx - sel_len;
  end

  // Byte to send at the current index
  always_comb
  begin
    tx_byte = 8'h00;
    if (s_reg.idx < sel_len && !s_reg.multi)
      tx_byte = GLOBAL_SELECT_CMD;
    else if (s_reg.idx == 5'h0)
      tx_byte = UNIQUE_SELECT_CMD;
    else if (s_reg.idx < sel_len)
      tx_byte = s_reg.id[3'(s_reg.idx - 5'h1)];
    else if (k == 5'h0)
      case (s_reg.ph)
        P_STAGE: tx_byte = STAGE_WRITE_CMD;
        P_VERIFY: tx_byte = STAGE_READ_CMD;
        P_COPY: tx_byte = STAGE_COPY_CMD;
        default: tx_byte = READ_EEPROM_CMD;
      endcase
    else if (s_reg.ph == P_COPY)
      tx_byte = COPY_QUALIFIER;
    else if (k == 5'h1)
      tx_byte = s_reg.addr[15:8];
    else if (k == 5'h2)
      tx_byte = s_reg.addr[7:0];
    else
      tx_byte = s_reg.wd[3'(k - 5'h3)];
  end

  // Next-state logic of the host sequencer
  always_comb
  begin
    s_next = s_reg;
    s_next.rst = 1'b0;
    s_next.hv = 1'b0;
    s_next.rq = 1'b0;
    s_next.done = 1'b0;
    case (s_reg.state)
      H_IDLE:
        if (START_IN)
        begin
          s_next.multi = MULTI_IN;
          s_next.id = DEV_ID_IN;
          s_next.addr = ADDR_IN;
          s_next.wd = WDATA_IN;
          s_next.ph = OP_IN ? P_READ : P_STAGE;
          s_next.busy = 1'b1;
          s_next.err = 1'b0;
          s_next.crc_ok = 1'b0;
          s_next.state = H_RST;
        end
      H_RST:
      begin
        // every transaction opens with a bus reset
        s_next.rst = 1'b1;
        s_next.wcnt = 16'h0;
        s_next.state = H_PRES;
      end
      H_PRES:
        if (LINK.presence)
        begin
          s_next.idx = 5'h0;
          s_next.crc = CRC_INIT;
          s_next.state = H_TX;
        end
        else if (s_reg.wcnt == PRESENCE_TIMEOUT_CYCLES - 16'h1)
        begin
          s_next.err = 1'b1;
          s_next.state = H_END;
        end
        else
          s_next.wcnt = s_reg.wcnt + 16'h1;
      H_TX:
      begin
        s_next.hv = 1'b1;
        s_next.hd = tx_byte;
        s_next.idx = s_reg.idx + 5'h1;
        if (s_reg.ph == P_STAGE && s_reg.idx > sel_len)
        begin
          // expected crc over address and data
          s_next.crc = epvs_crc8(s_reg.crc, tx_byte);
        end
        if (s_reg.idx == tx_len - 5'h1)
        begin
          s_next.rcnt = (s_reg.ph == P_STAGE) ? PAGE_BYTES : 4'h0;
          s_next.pend = 1'b0;
          if (s_reg.ph == P_COPY)
          begin
            // idle for the whole programming time
            s_next.wcnt = PROGRAM_IDLE_CYCLES;
            s_next.state = H_WAIT;
          end
          else if (s_reg.ph == P_READ)
          begin
            s_next.wcnt = PREFETCH_IDLE_CYCLES;
            s_next.state = H_WAIT;
          end
          else
          begin
            s_next.state = H_RX;
          end
        end
      end
      H_WAIT:
        if (s_reg.wcnt == 16'h0)
          s_next.state = (s_reg.ph == P_COPY) ? H_END : H_RX;
        else
          s_next.wcnt = s_reg.wcnt - 16'h1;
      H_RX:
        if (!s_reg.pend)
        begin
          s_next.rq = 1'b1;
          s_next.pend = 1'b1;
        end
        else if (LINK.d_valid)
        begin
          s_next.pend = 1'b0;
          if (s_reg.rcnt != PAGE_BYTES)
          begin
            s_next.rd[s_reg.rcnt[2:0]] = LINK.d_data;
            s_next.crc = epvs_crc8(s_reg.crc, LINK.d_data);
            s_next.rcnt = s_reg.rcnt + 4'h1;
          end
          else if (s_reg.ph == P_STAGE)
          begin
            if (LINK.d_data == s_reg.crc)
            begin
              s_next.ph = P_VERIFY;
              s_next.state = H_RST;
            end
            else
            begin
              s_next.err = 1'b1;
              s_next.state = H_END;
            end
          end
          else if (s_reg.ph == P_VERIFY)
          begin
            // commit only after a clean verify
            if (LINK.d_data == s_reg.crc && s_reg.rd == s_reg.wd)
            begin
              s_next.ph = P_COPY;
              s_next.state = H_RST;
            end
            else
            begin
              s_next.err = 1'b1;
              s_next.state = H_END;
            end
          end
          else
          begin
            s_next.crc_ok = (LINK.d_data == s_reg.crc);
            s_next.err = (LINK.d_data != s_reg.crc);
            s_next.state = H_END;
          end
        end
      H_END:
      begin
        s_next.done = 1'b1;
        s_next.busy = 1'b0;
        s_next.crc_ok = s_reg.crc_ok | (s_reg.ph == P_COPY && !s_reg.err);
        s_next.state = H_IDLE;
      end
      default:
        s_next.state = H_IDLE;
    endcase
    if (!NRST_IN)
    begin
      s_next = '0;
    end
  end

  // State register
  always_ff @(posedge CLK_IN)
  begin
    s_reg <= s_next;
  end

  // Link and user outputs from the state register
  assign LINK.bus_reset = s_reg.rst;
  assign LINK.h_valid = s_reg.hv;
  assign LINK.h_data = s_reg.hd;
  assign LINK.rd_req = s_reg.rq;
  assign BUSY_OUT = s_reg.busy;
  assign DONE_OUT = s_reg.done;
  assign ERROR_OUT = s_reg.err;
  assign CRC_OK_OUT = s_reg.crc_ok;
  assign RDATA_OUT = s_reg.rd;
endmodule : epvs_host

// >>> tb/epvs_link_properties.sv
`timescale 1ns/100ps
module epvs_link_properties
  import epvs_pkg::*;
(
  input wire logic CLK_IN,
  input wire logic NRST_IN,
  input wire logic bus_reset,
  input wire logic presence,
  input wire logic h_valid,
  input wire logic [7:0] h_data,
  input wire logic rd_req,
  input wire logic d_valid,
  input wire logic [7:0] d_data
);
  logic [15:0] quiet_cnt_reg;

  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (!NRST_IN);

  // Link steps that open the timed phases
  sequence s_commit;
    h_valid && h_data == STAGE_COPY_CMD ##1 h_valid && h_data == COPY_QUALIFIER;
  endsequence
  sequence s_read_cmd;
    h_valid && h_data == READ_EEPROM_CMD ##1 h_valid ##1 h_valid;
  endsequence
  sequence s_write_cmd;
    h_valid && h_data == GLOBAL_SELECT_CMD ##1 h_valid && h_data == STAGE_WRITE_CMD;
  endsequence
  sequence s_quiet;
    !(bus_reset || h_valid || rd_req);
  endsequence

  // Counts the programming span after a commit
  always_ff @(posedge CLK_IN)
  begin
    if (!NRST_IN)
      quiet_cnt_reg <= 16'h0000;
    else if (h_valid && h_data == COPY_QUALIFIER && $past(h_valid) && $past(h_data) == STAGE_COPY_CMD)
      quiet_cnt_reg <= PROGRAM_IDLE_CYCLES;
    else if (quiet_cnt_reg != 16'h0000)
      quiet_cnt_reg <= quiet_cnt_reg - 16'h0001;
  end

  property p_presence;
    bus_reset |=> presence;
  endproperty
  property p_presence_cause;
    presence |-> $past(bus_reset);
  endproperty
  property p_select;
    presence |=> !h_valid ##1 h_valid && (h_data == GLOBAL_SELECT_CMD || h_data == UNIQUE_SELECT_CMD);
  endproperty
  property p_answer;
    rd_req |=> d_valid && !rd_req;
  endproperty
  property p_answer_cause;
    d_valid |-> $past(rd_req);
  endproperty
  property p_write_frame;
    s_write_cmd |=> h_valid [*8] ##1 h_valid ##1 h_valid ##1 rd_req ##1 d_valid;
  endproperty
  property p_prog_quiet;
    s_commit |=> s_quiet [*8];
  endproperty
  property p_prog_span;
    quiet_cnt_reg != 16'h0000 |-> s_quiet;
  endproperty
  property p_prefetch;
    s_read_cmd |=> (!rd_req && !d_valid) [*8] ##[1:100] d_valid;
  endproperty

  a_presence: assert property (p_presence) else $error("no presence after bus reset");
  a_presence_cause: assert property (p_presence_cause) else $error("presence without reset");
  a_select: assert property (p_select) else $error("no select after presence");
  a_answer: assert property (p_answer) else $error("read request unanswered");
  a_answer_cause: assert property (p_answer_cause) else $error("byte without request");
  a_write_frame: assert property (p_write_frame) else $error("stage write frame wrong");
  a_prog_quiet: assert property (p_prog_quiet) else $error("link busy after commit");
  a_prog_span: assert property (p_prog_span) else $error("link busy while programming");
  a_prefetch: assert property (p_prefetch) else $error("prefetch idle broken");
endmodule : epvs_link_properties

// >>> tb/tb_eeprom_program_verify_seq.sv
`timescale 1ns/100ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin errors++; \
  $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module tb_eeprom_program_verify_seq;
  import epvs_pkg::*;
  localparam logic [63:0] TB_ID = 64'h1122_3344_6677_8899; // arbitrary value
  localparam logic [63:0] PAGE = 64'h8877_6644_3322_1100;
  logic clk, rst_n, start, op, multi, busy, done, err, crc_ok, busy_a, sel_a, busy_b, sel_b;
  logic [63:0] dev_id, rdata;
  logic [7:0] cap[$];
  logic [7:0] bq[$];
  logic [7:0] pg[$];
  int errors = 0;
  int tests_run = 0;

  epvs_link_if link_a();
  epvs_link_if link_b();
  epvs_host i_epvs_host(.CLK_IN(clk), .NRST_IN(rst_n), .LINK(link_a), .START_IN(start), .OP_IN(op),
    .MULTI_IN(multi), .DEV_ID_IN(dev_id), .ADDR_IN(16'h0010), .WDATA_IN(PAGE), .BUSY_OUT(busy),
    .DONE_OUT(done), .ERROR_OUT(err), .CRC_OK_OUT(crc_ok), .RDATA_OUT(rdata));
  epvs_device #(.DEV_ID(TB_ID)) i_epvs_device(.CLK_IN(clk), .NRST_IN(rst_n), .LINK(link_a),
    .PROG_BUSY_OUT(busy_a), .SELECTED_OUT(sel_a));
  // Second device driven directly by the bench
  epvs_device i_epvs_device_b(.CLK_IN(clk), .NRST_IN(rst_n), .LINK(link_b), .PROG_BUSY_OUT(busy_b),
    .SELECTED_OUT(sel_b));
  epvs_link_properties i_epvs_link_properties(.CLK_IN(clk), .NRST_IN(rst_n), .bus_reset(link_a.bus_reset),
    .presence(link_a.presence), .h_valid(link_a.h_valid), .h_data(link_a.h_data), .rd_req(link_a.rd_req),
    .d_valid(link_a.d_valid), .d_data(link_a.d_data));

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Collects every byte the device answers
  always @(negedge clk)
    if (link_a.d_valid === 1'b1)
      cap.push_back(link_a.d_data);

  task tick();
    @(posedge clk);
    #10;
  endtask : tick

  function automatic logic [7:0] crc(input logic [7:0] q[$]);
    logic [7:0] c;
    c = 8'h00;
    foreach (q[i])
      for (int k = 0; k < 8; k++)
        c = ((c[0] ^ q[i][k]) ? 8'h8c : 8'h00) ^ (c >> 1);
    return c;
  endfunction : crc

  task end_of_test();
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_of_test

  task automatic host_job(input logic o, input logic m);
    int n;
    cap = {};
    op = o;
    multi = m;
    start = 1'b1;
    tick();
    start = 1'b0;
    `CHK(busy, 1'b1)
    n = 0;
    while (done !== 1'b1 && n < 3000)
    begin
      tick();
      n++;
    end
    `CHK(done, 1'b1)
    `CHK(busy, 1'b0)
  endtask : host_job

  // Direct link helpers: reset, byte string, one read
  task b_open();
    link_b.bus_reset = 1'b1;
    tick();
    link_b.bus_reset = 1'b0;
    `CHK(link_b.presence, 1'b1)
  endtask : b_open

  task automatic b_send(input logic [7:0] q[$]);
    foreach (q[i])
    begin
      link_b.h_valid = 1'b1;
      link_b.h_data = q[i];
      tick();
    end
    link_b.h_valid = 1'b0;
  endtask : b_send

  task automatic b_read(output logic [7:0] d);
    link_b.rd_req = 1'b1;
    tick();
    link_b.rd_req = 1'b0;
    `CHK(link_b.d_valid, 1'b1)
    d = link_b.d_data;
    tick();
  endtask : b_read

  task automatic t_program(input logic m);
    host_job(1'b0, m);
    bq = {8'h00, 8'h10};
    bq = {bq, pg};
    `CHK(err, 1'b0)
    `CHK(crc_ok, 1'b1)
    `CHK(busy_a, 1'b0)
    `CHK(cap[0], crc(bq))
    for (int i = 0; i < 8; i++)
      `CHK(cap[i + 1], pg[i])
    `CHK(cap[9], crc(pg))
  endtask : t_program

  task automatic t_read();
    host_job(1'b1, 1'b1);
    `CHK(rdata, PAGE)
    `CHK(sel_a, 1'b1)
    `CHK(crc_ok, 1'b1)
    `CHK(cap[8], crc(pg))
  endtask : t_read

  task automatic t_direct();
    logic [7:0] d;
    logic [15:0] n;
    bq = {GLOBAL_SELECT_CMD, STAGE_WRITE_CMD, 8'h00, 8'hf8};
    bq = {bq, pg};
    b_open();
    b_send(bq);
    `CHK(sel_b, 1'b1)
    b_read(d);
    `CHK(d, crc(bq[2:11]))
    // Short select: own address only
    bq = {SHORT_ADDRESS_SELECT_CMD, 8'h02};
    b_open();
    b_send(bq);
    `CHK(sel_b, 1'b0)
    bq = {SHORT_ADDRESS_SELECT_CMD, 8'h01};
    b_open();
    b_send(bq);
    `CHK(sel_b, 1'b1)
    // Wrong qualifier must not start programming
    bq = {GLOBAL_SELECT_CMD, STAGE_COPY_CMD, 8'h5a};
    b_open();
    b_send(bq);
    repeat (4) tick();
    `CHK(busy_b, 1'b0)
    bq = {GLOBAL_SELECT_CMD, READ_EEPROM_CMD, 8'h00, 8'hf8};
    b_open();
    b_send(bq);
    repeat (PREFETCH_IDLE_CYCLES + 1) tick();
    b_read(d);
    `CHK(d, EE_ERASED)
    // Proper commit and its busy span
    bq = {GLOBAL_SELECT_CMD, STAGE_COPY_CMD, COPY_QUALIFIER};
    b_open();
    b_send(bq);
    repeat (3)
      if (busy_b !== 1'b1)
        tick();
    n = 16'h0000;
    while (busy_b === 1'b1 && n < 16'h0fff)
    begin
      tick();
      n++;
    end
    `CHK(n, PROGRAM_IDLE_CYCLES)
    // Read the last page, then past the end
    bq = {GLOBAL_SELECT_CMD, READ_EEPROM_CMD, 8'h00, 8'hf8};
    b_open();
    b_send(bq);
    repeat (PREFETCH_IDLE_CYCLES + 1) tick();
    for (int i = 0; i < 8; i++)
    begin
      b_read(d);
      `CHK(d, pg[i])
    end
    b_read(d);
    `CHK(d, crc(pg))
    repeat (PREFETCH_IDLE_CYCLES + 1) tick();
    repeat (2)
    begin
      b_read(d);
      `CHK(d, PAST_END_BYTE)
    end
  endtask : t_direct

  // Watchdog on the whole run
  initial
  begin
    #(100 * 20000);
    errors++;
    end_of_test();
  end

  // Reset, then the scenarios in order
  initial
  begin
    rst_n = 1'b0;
    start = 1'b0;
    op = 1'b0;
    multi = 1'b0;
    dev_id = TB_ID;
    link_b.bus_reset = 1'b0;
    link_b.h_valid = 1'b0;
    link_b.h_data = 8'h00;
    link_b.rd_req = 1'b0;
    for (int i = 0; i < 8; i++)
      pg.push_back(PAGE[8 * i +: 8]);
    repeat (5) tick();
    rst_n = 1'b1;
    t_program(1'b0);
    t_program(1'b1);
    t_read();
    t_direct();
    end_of_test();
  end
endmodule : tb_eeprom_program_verify_seq
